// ==== mmac_pkg.sv ====
// Package: register map, carriers and state of the mailbox mask unit
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package mmac_pkg;

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned FRAME_SEL_BIT = 12;
    localparam logic [11:0] OFF_RAW = 12'h000;
    localparam logic [11:0] OFF_MASKED = 12'h004;
    localparam logic [11:0] OFF_FLAG_CLR = 12'h008;
    localparam logic [11:0] OFF_FLAG_SET = 12'h00C;
    localparam logic [11:0] OFF_MASK_ST = 12'h010;
    localparam logic [11:0] OFF_MASK_SET = 12'h014;
    localparam logic [11:0] OFF_MASK_CLR = 12'h018;
    localparam logic [11:0] OFF_RSVD_1C = 12'h01C;
    localparam logic [11:0] OFF_WIN_END = 12'h020;
    localparam logic [11:0] OFF_CFG = 12'hF80;
    localparam logic [11:0] OFF_RESP = 12'hF84;
    localparam logic [11:0] OFF_REQ = 12'hF88;
    localparam logic [11:0] OFF_RDY = 12'hF8C;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_W = 32;
    localparam int unsigned COUNT_W = 7;
    localparam logic [6:0] COUNT_MAX = 7'h7C;
    localparam logic [6:0] COUNT_FALLBACK = 7'h01;
    localparam int unsigned REQ_BIT = 0;
    localparam int unsigned RDY_BIT = 0;
    localparam int unsigned OPT_BIT = 0;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] RAW_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic REQ_RST = 1'b0;
    localparam logic RDY_RST = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } mmac_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } mmac_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mmac_apb_rsp_t;

    typedef struct packed {
        mmac_state_t state;
        logic [FLAG_W-1:0] raw;
        logic [FLAG_W-1:0] mask;
        logic req;
        logic rdy;
        logic irq;
        mmac_apb_rsp_t rsp;
    } mmac_regs_t;

endpackage : mmac_pkg

// ==== mmac_mask_gate.sv ====
// Module: per-channel gating of raw flags by the channel mask
`timescale 1ns/10ps
module mmac_mask_gate #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic [WIDTH-1:0] i_raw,
    input wire logic [WIDTH-1:0] i_mask,
    output logic [WIDTH-1:0] o_masked,
    output logic o_any
);

    // ------------------------------------------------------------------
    // Gate each flag by its own mask bit
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // Mask 0 passes the flag, mask 1 forces zero
            assign o_masked[g] = i_raw[g] & ~i_mask[g];
        end
    endgenerate

    // Combined level: any unmasked flag raised
    assign o_any = |o_masked;

endmodule : mmac_mask_gate

// ==== mmac_top.sv ====
// Module: mailbox mask, configuration and access-ready unit, APB slave
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module mmac_top #(
    parameter logic [6:0] CHANNEL_COUNT = 7'h01,
    parameter logic BLOCKED_ERR = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire mmac_pkg::mmac_apb_req_t i_apb,
    output mmac_pkg::mmac_apb_rsp_t o_apb,
    output logic o_chan_irq,
    output logic o_access_request,
    output logic o_receiver_ready
);

    // ------------------------------------------------------------------
    // Build-time constants
    // ------------------------------------------------------------------
    // Illegal counts fall back so a reserved code is never reported
    localparam logic [6:0] COUNT_REPORTED =
        (CHANNEL_COUNT == 7'h00 || CHANNEL_COUNT > mmac_pkg::COUNT_MAX)
        ? mmac_pkg::COUNT_FALLBACK : CHANNEL_COUNT;

    // Option bit is a parameter; software cannot alter it
    localparam logic RESP_OPT = BLOCKED_ERR;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mmac_pkg::mmac_regs_t st_reg;
    mmac_pkg::mmac_regs_t st_next;

    // ------------------------------------------------------------------
    // Decode wires
    // ------------------------------------------------------------------
    logic recv_frame;
    logic [11:0] offset;
    logic in_window;
    logic blocked;
    logic access;
    logic [31:0] byte_mask;
    logic [31:0] wbits;
    logic [mmac_pkg::FLAG_W-1:0] masked;
    logic masked_any;

    // Frame select: receiver frame on the top address bit
    assign recv_frame = i_apb.paddr[mmac_pkg::FRAME_SEL_BIT];
    assign offset = i_apb.paddr[11:0];

    // Channel window spans the first block of offsets
    assign in_window = offset < mmac_pkg::OFF_WIN_END;

    // Sender window access while receiver cannot accept
    assign blocked = !recv_frame && in_window && !st_reg.rdy;

    // Access phase of a transfer addressed to this slave
    assign access = i_apb.psel && i_apb.penable;

    // Byte lanes honoured on writes
    assign byte_mask = {{8{i_apb.pstrb[3]}},
                        {8{i_apb.pstrb[2]}},
                        {8{i_apb.pstrb[1]}},
                        {8{i_apb.pstrb[0]}}};
    assign wbits = i_apb.pwdata & byte_mask;

    // ------------------------------------------------------------------
    // Mask gating of the raw flags
    // ------------------------------------------------------------------
    mmac_mask_gate #(
        .WIDTH(mmac_pkg::FLAG_W)
    ) u_gate (
        .i_raw(st_reg.raw),
        .i_mask(st_reg.mask),
        .o_masked(masked),
        .o_any(masked_any)
    );

    // ------------------------------------------------------------------
    // Read mux and error decode for the current address
    // ------------------------------------------------------------------
    logic [31:0] rd_data;
    logic rd_err;

    // Blocked and unmapped reads give zero; reserved bits zero-filled
    always_comb begin
        rd_data = mmac_pkg::ZERO_WORD;
        rd_err = 1'b0;
        if (blocked) begin
            rd_data = mmac_pkg::ZERO_WORD;
            rd_err = RESP_OPT;
        end else begin
            unique case (offset)
                mmac_pkg::OFF_RAW: begin
                    rd_data = st_reg.raw;
                end
                mmac_pkg::OFF_MASKED: begin
                    if (recv_frame) begin
                        rd_data = masked;
                    end else begin
                        rd_err = 1'b1;
                    end
                end
                mmac_pkg::OFF_FLAG_CLR: begin
                    // Write-only, reads as zero
                    rd_err = !recv_frame;
                end
                mmac_pkg::OFF_FLAG_SET: begin
                    // Write-only in sender frame, reserved otherwise
                    rd_data = mmac_pkg::ZERO_WORD;
                end
                mmac_pkg::OFF_MASK_ST: begin
                    if (recv_frame) begin
                        rd_data = st_reg.mask;
                    end else begin
                        rd_err = 1'b1;
                    end
                end
                mmac_pkg::OFF_MASK_SET: begin
                    rd_data = mmac_pkg::ZERO_WORD;
                    rd_err = !recv_frame;
                end
                mmac_pkg::OFF_MASK_CLR: begin
                    rd_data = mmac_pkg::ZERO_WORD;
                    rd_err = !recv_frame;
                end
                mmac_pkg::OFF_RSVD_1C: begin
                    rd_data = mmac_pkg::ZERO_WORD;
                end
                mmac_pkg::OFF_CFG: begin
                    rd_data = {25'h000_0000, COUNT_REPORTED};
                end
                mmac_pkg::OFF_RESP: begin
                    rd_data = {31'h0000_0000, RESP_OPT};
                end
                mmac_pkg::OFF_REQ: begin
                    rd_data = {31'h0000_0000, st_reg.req};
                end
                mmac_pkg::OFF_RDY: begin
                    rd_data = {31'h0000_0000, st_reg.rdy};
                end
                default: begin
                    // Unmapped address: zero data and slave error
                    rd_err = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Write decode: one-hot strobes per writable target
    // ------------------------------------------------------------------
    logic wr_ok;
    logic [31:0] flag_set;
    logic [31:0] flag_clr;
    logic [31:0] mask_set;
    logic [31:0] mask_clr;
    logic req_we;
    logic rdy_we;

    // Write lands only on the edge that completes the transfer
    assign wr_ok = access && i_apb.pwrite && st_reg.rsp.pready && !blocked;

    // Decode of each write target; blocked writes are dropped
    always_comb begin
        flag_set = mmac_pkg::ZERO_WORD;
        flag_clr = mmac_pkg::ZERO_WORD;
        mask_set = mmac_pkg::ZERO_WORD;
        mask_clr = mmac_pkg::ZERO_WORD;
        req_we = 1'b0;
        rdy_we = 1'b0;
        if (wr_ok) begin
            unique case (offset)
                mmac_pkg::OFF_FLAG_SET: begin
                    if (!recv_frame) begin
                        flag_set = wbits;
                    end
                end
                mmac_pkg::OFF_FLAG_CLR: begin
                    if (recv_frame) begin
                        flag_clr = wbits;
                    end
                end
                mmac_pkg::OFF_MASK_SET: begin
                    if (recv_frame) begin
                        mask_set = wbits;
                    end
                end
                mmac_pkg::OFF_MASK_CLR: begin
                    if (recv_frame) begin
                        mask_clr = wbits;
                    end
                end
                mmac_pkg::OFF_REQ: begin
                    // Only the sender owns the request bit
                    req_we = !recv_frame && i_apb.pstrb[0];
                end
                mmac_pkg::OFF_RDY: begin
                    // Receiver reports readiness; sender view is read-only
                    rdy_we = recv_frame && i_apb.pstrb[0];
                end
                default: begin
                    // Read-only and reserved words ignore writes
                    req_we = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Bus answers after one wait state so every output stays registered
    always_comb begin
        st_next = st_reg;

        // Flags: set wins when set and clear meet on the same bit
        st_next.raw = (st_reg.raw & ~flag_clr) | flag_set;

        // Mask: write-one-to-set and write-one-to-clear
        st_next.mask = (st_reg.mask | mask_set) & ~mask_clr;

        // Request bit, bit 0 only; upper bits discarded
        if (req_we) begin
            st_next.req = wbits[mmac_pkg::REQ_BIT];
        end

        // Ready bit, bit 0 only
        if (rdy_we) begin
            st_next.rdy = wbits[mmac_pkg::RDY_BIT];
        end

        // Combined channel interrupt from the gated flags
        st_next.irq = masked_any;

        unique case (st_reg.state)
            mmac_pkg::ST_IDLE: begin
                st_next.rsp.pready = 1'b0;
                st_next.rsp.pslverr = 1'b0;
                st_next.rsp.prdata = mmac_pkg::ZERO_WORD;
                if (access) begin
                    // Capture the answer; writes read back as zero
                    st_next.state = mmac_pkg::ST_DONE;
                    st_next.rsp.pready = 1'b1;
                    st_next.rsp.pslverr = rd_err;
                    if (!i_apb.pwrite) begin
                        st_next.rsp.prdata = rd_data;
                    end
                end
            end
            mmac_pkg::ST_DONE: begin
                // Master samples the answer on this edge
                st_next.state = mmac_pkg::ST_IDLE;
                st_next.rsp.pready = 1'b0;
                st_next.rsp.pslverr = 1'b0;
                st_next.rsp.prdata = mmac_pkg::ZERO_WORD;
            end
            default: begin
                // Illegal code: return to idle with a quiet bus
                st_next.state = mmac_pkg::ST_IDLE;
                st_next.rsp.pready = 1'b0;
                st_next.rsp.pslverr = 1'b0;
                st_next.rsp.prdata = mmac_pkg::ZERO_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous active-low reset to fixed constants
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_reg.state <= mmac_pkg::ST_IDLE;
            st_reg.raw <= mmac_pkg::RAW_RST;
            st_reg.mask <= mmac_pkg::MASK_RST;
            st_reg.req <= mmac_pkg::REQ_RST;
            st_reg.rdy <= mmac_pkg::RDY_RST;
            st_reg.irq <= 1'b0;
            st_reg.rsp.prdata <= mmac_pkg::ZERO_WORD;
            st_reg.rsp.pready <= 1'b0;
            st_reg.rsp.pslverr <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign o_apb = st_reg.rsp;
    assign o_chan_irq = st_reg.irq;
    assign o_access_request = st_reg.req;
    assign o_receiver_ready = st_reg.rdy;

endmodule : mmac_top

// ==== mmac_top_asserts.sv ====
// Checker: bus answers, register fields and pins of the mask unit
`timescale 1ns/10ps
module mmac_top_asserts #(
    parameter logic [6:0] CHANNEL_COUNT = 7'h01,
    parameter logic BLOCKED_ERR = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire mmac_pkg::mmac_apb_req_t i_apb,
    input wire mmac_pkg::mmac_apb_rsp_t o_apb,
    input wire logic o_chan_irq,
    input wire logic o_access_request,
    input wire logic o_receiver_ready
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic rd_ans;
    logic wr_ans;
    logic [11:0] off;
    logic [6:0] exp_cnt;
    // Answer cycles and the offset they belong to
    assign rd_ans = o_apb.pready && !i_apb.pwrite;
    assign wr_ans = o_apb.pready && i_apb.pwrite && !o_apb.pslverr;
    assign off = i_apb.paddr[11:0];
    // Reserved counts fall back, so software never sees them
    assign exp_cnt = (CHANNEL_COUNT == 7'h00 ||
        CHANNEL_COUNT > mmac_pkg::COUNT_MAX) ? 7'h01 : CHANNEL_COUNT;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_cfg_count: assert property (
        rd_ans && off == 12'hF80 |-> o_apb.prdata == {25'h0, exp_cnt})
        else $error("config word shows wrong count");
    chk_opt_fixed: assert property (
        rd_ans && off == 12'hF84 |-> o_apb.prdata == {31'h0, BLOCKED_ERR})
        else $error("option word differs from build value");
    chk_set_clr_raz: assert property (
        rd_ans && (off == 12'h014 || off == 12'h018) |-> o_apb.prdata == 0)
        else $error("mask set or clear read not zero");
    chk_blocked_resp: assert property (
        o_apb.pready && !i_apb.paddr[12] && !o_receiver_ready &&
        (off == 12'h000 || off == 12'h00C)
        |-> o_apb.prdata == 0 && o_apb.pslverr == BLOCKED_ERR)
        else $error("blocked sender access answered wrongly");
    chk_out_reset: assert property (
        $rose(i_rst_b) |-> !o_access_request && !o_receiver_ready
        && !o_chan_irq)
        else $error("pins not low after reset");
    chk_req_write: assert property (
        wr_ans && !i_apb.paddr[12] && off == 12'hF88 && i_apb.pstrb[0]
        |=> o_access_request == $past(i_apb.pwdata[0]))
        else $error("request pin does not follow write");
    chk_rdy_field: assert property (
        rd_ans && off == 12'hF8C |-> o_apb.prdata == {31'h0, o_receiver_ready})
        else $error("ready word differs from ready pin");
    chk_req_field: assert property (
        rd_ans && off == 12'hF88 |-> o_apb.prdata == {31'h0, o_access_request})
        else $error("request word differs from request pin");
    chk_irq_follow: assert property (
        rd_ans && i_apb.paddr[12] && off == 12'h004 && |o_apb.prdata
        |-> ##[0:1] o_chan_irq)
        else $error("interrupt low with masked flags set");
endmodule : mmac_top_asserts

bind mmac_top mmac_top_asserts #(.CHANNEL_COUNT(CHANNEL_COUNT),
    .BLOCKED_ERR(BLOCKED_ERR)) i_mmac_top_asserts (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_apb(i_apb),
    .o_apb(o_apb), .o_chan_irq(o_chan_irq),
    .o_access_request(o_access_request),
    .o_receiver_ready(o_receiver_ready));

// ==== mmac_apb_agent.sv ====
// Partner: processor-side APB master used by sender and receiver
`timescale 1ns/10ps
module mmac_apb_agent (
    input wire logic i_core_clk,
    input wire mmac_pkg::mmac_apb_rsp_t i_rsp,
    output mmac_pkg::mmac_apb_req_t o_req
);
    // Idle bus from time zero
    initial begin
        o_req = '0;
    end

    // Setup, access, hold until pready; ok stays low on a hang
    task automatic xfer(input logic wr, input logic [12:0] a,
        input logic [31:0] d, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge i_core_clk);
        o_req.psel <= 1'b1;
        o_req.penable <= 1'b0;
        o_req.pwrite <= wr;
        o_req.paddr <= a;
        o_req.pwdata <= d;
        o_req.pstrb <= 4'hF;
        @(posedge i_core_clk);
        o_req.penable <= 1'b1;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge i_core_clk);
            ok = (i_rsp.pready === 1'b1);
        end
        // Inverted data after release, so stale data never looks held
        o_req.psel <= 1'b0;
        o_req.penable <= 1'b0;
        o_req.pwdata <= ~d;
    endtask : xfer
endmodule : mmac_apb_agent

// ==== mailbox_mask_and_access_ctrl_tb.sv ====
// Testbench: mailbox mask and access-ready unit over APB
`timescale 1ns/10ps
module mailbox_mask_and_access_ctrl_tb;
    localparam logic [6:0] CNT = 7'h7C;
    localparam logic ERR = 1'b1;
    typedef struct packed {
        logic rd;
        logic [11:0] a;
        logic [31:0] d;
        logic e;
        logic b;
    } mmac_note_t;
    logic i_core_clk;
    logic i_rst_b;
    mmac_pkg::mmac_apb_req_t apb_req;
    mmac_pkg::mmac_apb_rsp_t apb_rsp;
    mmac_pkg::mmac_apb_rsp_t apb_rsp0;
    logic rdy_model = 1'b0;
    logic [31:0] d0;
    logic e0;
    logic chan_irq;
    logic acc_req;
    logic rcv_rdy;
    mmac_note_t notes[$];
    mmac_note_t nt;
    int n_errors = 0;
    int check_count = 0;
    integer seed = 32'h3ad0b838;
    logic [31:0] r;
    logic [31:0] m;
    logic [31:0] c;

    // ------------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------------
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    mmac_top #(.CHANNEL_COUNT(CNT), .BLOCKED_ERR(ERR)) i_mmac_top (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_apb(apb_req),
        .o_apb(apb_rsp), .o_chan_irq(chan_irq),
        .o_access_request(acc_req), .o_receiver_ready(rcv_rdy));
    // Second build on the same bus: reserved count, okay on blocked access
    mmac_top #(.CHANNEL_COUNT(7'h00), .BLOCKED_ERR(1'b0)) i_mmac_top_b (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_apb(apb_req),
        .o_apb(apb_rsp0), .o_chan_irq(), .o_access_request(),
        .o_receiver_ready());
    mmac_apb_agent i_mmac_apb_agent (.i_core_clk(i_core_clk),
        .i_rsp(apb_rsp), .o_req(apb_req));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // Note the expected answer first, then run the transfer
    task automatic bus(input logic wr, input logic [12:0] a,
        input logic [31:0] d, input logic [31:0] x, input logic e);
        logic ok;
        logic b;
        // Sender window while the receiver is not ready is blocked
        b = !a[12] && a[11:0] < 12'h020 && !rdy_model;
        notes.push_back('{!wr, a[11:0], x, e, b});
        if (wr && a == 13'h1F8C) begin
            rdy_model = d[0];
        end
        i_mmac_apb_agent.xfer(wr, a, d, ok);
        chk("pready", 32'h0000_0001, {31'h0, ok});
        if (!ok) begin
            stop_test();
        end
    endtask : bus

    task automatic rd(input logic [12:0] a, input logic [31:0] x,
        input logic e);
        bus(1'b0, a, 32'h0000_0000, x, e);
    endtask : rd

    task automatic wr(input logic [12:0] a, input logic [31:0] d,
        input logic e);
        bus(1'b1, a, d, 32'h0000_0000, e);
    endtask : wr

    // Each answer is held against the oldest note
    always @(posedge i_core_clk) begin
        if (i_rst_b && apb_rsp.pready === 1'b1) begin
            if (notes.size() == 0) begin
                chk("spare answer", 32'h0000_0000, 32'h0000_0001);
            end else begin
                nt = notes.pop_front();
                chk("pslverr", {31'h0, nt.e}, {31'h0, apb_rsp.pslverr});
                // Second build: blocked accesses answer okay
                e0 = nt.e && !nt.b;
                chk("pready0", 32'h1, {31'h0, apb_rsp0.pready});
                chk("pslverr0", 32'(e0), 32'(apb_rsp0.pslverr));
                // Reserved count falls back; option reads zero
                d0 = nt.d;
                if (nt.a == mmac_pkg::OFF_CFG) begin
                    d0 = {25'h0, mmac_pkg::COUNT_FALLBACK};
                end else if (nt.a == mmac_pkg::OFF_RESP) begin
                    d0 = 32'h0000_0000;
                end
                if (nt.rd) begin
                    chk("prdata", nt.d, apb_rsp.prdata);
                    chk("prdata0", d0, apb_rsp0.prdata);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_rst_b = 1'b0;
        r = $random(seed);
        m = $random(seed);
        c = $random(seed);
        repeat (6) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        chk("reset pins", 32'h0, {29'h0, chan_irq, acc_req, rcv_rdy});
        // Reset values, then sender blocked while receiver not ready
        rd(13'h1010, 32'h0000_0000, 1'b0);
        rd(13'h0F88, 32'h0000_0000, 1'b0);
        rd(13'h0F8C, 32'h0000_0000, 1'b0);
        wr(13'h000C, r, ERR);
        rd(13'h0000, 32'h0000_0000, ERR);
        rd(13'h1000, 32'h0000_0000, 1'b0);
        // Request and ready handshake, reserved bits stay zero
        wr(13'h0F88, 32'hFFFF_FFFF, 1'b0);
        rd(13'h0F88, 32'h0000_0001, 1'b0);
        chk("request pin", 32'h0000_0001, {31'h0, acc_req});
        wr(13'h1F8C, 32'hFFFF_FFFF, 1'b0);
        rd(13'h0F8C, 32'h0000_0001, 1'b0);
        chk("ready pin", 32'h1, {31'h0, rcv_rdy});
        // Flags through the mask, random set and clear patterns
        wr(13'h000C, r, 1'b0);
        rd(13'h1000, r, 1'b0);
        wr(13'h1014, m, 1'b0);
        rd(13'h1010, m, 1'b0);
        rd(13'h1004, r & ~m, 1'b0);
        rd(13'h1014, 32'h0000_0000, 1'b0);
        wr(13'h1018, c, 1'b0);
        rd(13'h1010, m & ~c, 1'b0);
        rd(13'h1018, 32'h0000_0000, 1'b0);
        wr(13'h1014, 32'hFFFF_FFFF, 1'b0);
        rd(13'h1004, 32'h0000_0000, 1'b0);
        wr(13'h1018, 32'hFFFF_FFFF, 1'b0);
        rd(13'h1004, r, 1'b0);
        chk("irq pin", {31'h0, |r}, {31'h0, chan_irq});
        // Build-time words ignore writes; unmapped offset errors
        wr(13'h0F80, 32'h0000_0000, 1'b0);
        wr(13'h0F84, 32'hFFFF_FFFE, 1'b0);
        rd(13'h1F80, {25'h0, CNT}, 1'b0);
        rd(13'h0F84, {31'h0, ERR}, 1'b0);
        rd(13'h0100, 32'h0000_0000, 1'b1);
        repeat (3) @(posedge i_core_clk);
        chk("open notes", 32'h0000_0000, 32'(notes.size()));
        stop_test();
    end
endmodule : mailbox_mask_and_access_ctrl_tb
